// File: include/hot_duty_pkg.sv
package hot_duty_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INTERVAL = 8'h04;
	localparam logic [7:0] OFS_CUR1 = 8'h08;
	localparam logic [7:0] OFS_CUR2 = 8'h0C;
	localparam logic [7:0] OFS_AVG1 = 8'h10;
	localparam logic [7:0] OFS_AVG2 = 8'h14;
	localparam logic [7:0] OFS_LIMIT1 = 8'h18;
	localparam logic [7:0] OFS_LIMIT2 = 8'h1C;
	localparam logic [7:0] OFS_STAT1 = 8'h20;
	localparam logic [7:0] OFS_STAT2 = 8'h24;
	localparam logic [7:0] OFS_INT_STAT = 8'h28;
	localparam logic [7:0] OFS_INT_CLR = 8'h2C;
	localparam logic [7:0] OFS_INT_EN = 8'h30;
	localparam logic [7:0] OFS_OVR = 8'h34;
	// Field positions
	localparam int CTRL_SHORT_BIT = 0;
	localparam int CTRL_SLEEP_LSB = 1;
	localparam int OVR_DUTY_LSB = 8;
	localparam int ST_FULL = 0;
	localparam int ST_B193 = 1;
	localparam int ST_B129 = 2;
	localparam int ST_B65 = 3;
	localparam int ST_B33 = 4;
	localparam int ST_B1 = 5;
	localparam int ST_NZ = 6;
	localparam int ST_LIMIT = 7;
	// Interrupt status: interval done ch1/ch2, limit exceeded ch1/ch2
	localparam int IRQ_DONE1 = 0;
	localparam int IRQ_DONE2 = 1;
	localparam int IRQ_LIM1 = 2;
	localparam int IRQ_LIM2 = 3;
	// Band thresholds
	localparam logic [7:0] TH_193 = 8'hC1;
	localparam logic [7:0] TH_129 = 8'h81;
	localparam logic [7:0] TH_65 = 8'h41;
	localparam logic [7:0] TH_33 = 8'h21;
	localparam logic [7:0] SLOT_LAST = 8'hFF;
	// Reset values
	localparam logic [15:0] INTERVAL_RST = 16'h0100;
	localparam logic [7:0] LIMIT_RST = 8'hFF;
	localparam logic [7:0] PWM_PRESCALE = 8'hFF;
	// Timing
	localparam int CLK_PERIOD_PSEC = 8000;
	localparam int RESP_TIME_PSEC = 10000000;
	localparam int RESP_CYC = RESP_TIME_PSEC / CLK_PERIOD_PSEC;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SLEEP_S0 = 2'b00,
		SLEEP_S3 = 2'b01,
		SLEEP_S45 = 2'b10
	} sleep_e;
endpackage

// File: rtl/pwm_override.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_override (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Duty in 1/256 steps
	input wire logic [7:0] duty_i,
	output logic pwm_o
);
	import hot_duty_pkg::*;
	typedef struct packed {
		logic [7:0] pre;
		logic [7:0] cnt;
		logic out;
	} pwm_s;
	pwm_s s, next_s;

	always_comb begin
		next_s = s;
		next_s.pre = s.pre + 8'h01;
		if (s.pre == PWM_PRESCALE) begin
			next_s.pre = 8'h00;
			next_s.cnt = s.cnt + 8'h01;
		end
		next_s.out = (s.cnt < duty_i);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign pwm_o = s.out;
endmodule
`default_nettype wire

// File: rtl/throttle_channel.sv
`timescale 1ns/1ps
`default_nettype none
module throttle_channel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic asserted_i,
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic [15:0] slot_len_i,
	input wire logic [7:0] limit_i,
	// Results
	output logic [7:0] cur_o,
	output logic [7:0] avg_o,
	output logic [7:0] status_o,
	output logic done_o,
	output logic over_o
);
	import hot_duty_pkg::*;
	typedef struct packed {
		logic [15:0] div_cnt;
		logic [15:0] hcnt;
		logic [7:0] slot;
		logic [8:0] slots_on;
		logic any;
		logic never_rel;
		logic first;
		logic [7:0] cur;
		logic [7:0] avg;
		logic [7:0] status;
		logic done;
		logic over;
	} chan_s;
	chan_s s, next_s;
	logic [15:0] len;
	logic [15:0] h_sum;
	logic wrap;
	logic [8:0] whole;
	logic [15:0] h_now;
	logic [8:0] on_now;
	logic [7:0] meas;
	logic [8:0] avg_sum;

	function automatic logic [7:0] band(input logic [7:0] m, input logic full,
			input logic [7:0] lim);
		band = 8'h00;
		band[ST_FULL] = full;
		band[ST_B193] = !full && (m >= TH_193);
		band[ST_B129] = (m >= TH_129) && (m < TH_193);
		band[ST_B65] = (m >= TH_65) && (m < TH_129);
		band[ST_B33] = (m >= TH_33) && (m < TH_65);
		band[ST_B1] = (m != 8'h00) && (m < TH_33);
		band[ST_NZ] = (m != 8'h00);
		band[ST_LIMIT] = (m > lim);
	endfunction

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.over = 1'b0;
		len = (slot_len_i == 16'h0000) ? 16'h0001 : slot_len_i;
		h_sum = s.hcnt + {15'h0000, asserted_i};
		// Each slot's worth of asserted clocks is one count; the rest carries on
		wrap = (h_sum >= len);
		h_now = wrap ? (h_sum - len) : h_sum;
		whole = s.slots_on + {8'h00, wrap};
		// A leftover of half a slot or more rounds up: half-count bias
		on_now = whole + {8'h00, ({h_now, 1'b0} >= {1'b0, len})};
		// Saturate 256 slots to 255; any throttling at all reads at least 1
		if (on_now[8]) begin
			meas = 8'hFF;
		end else if (on_now[7:0] == 8'h00 && (s.any || asserted_i)) begin
			meas = 8'h01;
		end else begin
			meas = on_now[7:0];
		end
		avg_sum = {1'b0, s.avg} + {1'b0, s.cur};
		if (!run_i) begin
			// Sleeping: cleared current, held average, fresh start on wake
			next_s.cur = 8'h00;
			next_s.first = 1'b1;
			next_s.div_cnt = 16'h0000;
			next_s.hcnt = 16'h0000;
			next_s.slot = 8'h00;
			next_s.slots_on = 9'h000;
			next_s.any = 1'b0;
			next_s.never_rel = 1'b1;
		end else if (restart_i) begin
			next_s.div_cnt = 16'h0000;
			next_s.hcnt = 16'h0000;
			next_s.slot = 8'h00;
			next_s.slots_on = 9'h000;
			next_s.any = 1'b0;
			next_s.never_rel = 1'b1;
		end else begin
			next_s.hcnt = h_now;
			next_s.slots_on = whole;
			next_s.any = s.any | asserted_i;
			next_s.never_rel = s.never_rel & asserted_i;
			next_s.div_cnt = s.div_cnt + 16'h0001;
			if (s.div_cnt >= len - 16'h0001) begin
				next_s.div_cnt = 16'h0000;
				next_s.slot = s.slot + 8'h01;
				if (s.slot == SLOT_LAST) begin
					next_s.cur = meas;
					// Average takes the previous reading, not this one; the first reading after reset or wake loads it directly
					next_s.avg = s.first ? meas : avg_sum[8:1];
					next_s.first = 1'b0;
					next_s.status = band(meas, s.never_rel & asserted_i, limit_i);
					next_s.done = 1'b1;
					next_s.over = (meas > limit_i);
					next_s.slots_on = 9'h000;
					next_s.hcnt = 16'h0000;
					next_s.any = 1'b0;
					next_s.never_rel = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '{first: 1'b1, never_rel: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end
	assign cur_o = s.cur;
	assign avg_o = s.avg;
	assign status_o = s.status;
	assign done_o = s.done;
	assign over_o = s.over;

	////////////////////////////////////////////////////////////////////////
	a_sleep_clears_cur: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_i |=> (cur_o == 8'h00 && avg_o == $past(avg_o)))
		else $error("current reading not cleared in sleep");
	a_avg_prev_value: assert property (@(posedge clk_i) disable iff (rst_i)
		(run_i && !restart_i && s.slot == SLOT_LAST && s.div_cnt >= len - 16'h0001 && !s.first)
		|=> {1'b0, avg_o} == (({1'b0, $past(avg_o)} + {1'b0, $past(cur_o)}) >> 1))
		else $error("average not built from old current value");
	a_nonzero_floor: assert property (@(posedge clk_i) disable iff (rst_i)
		done_o |-> (status_o[ST_NZ] == (cur_o != 8'h00)) && (cur_o >= {7'h00, status_o[ST_NZ]}))
		else $error("nonzero flag disagrees with reading");
	a_limit_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		done_o |-> status_o[ST_LIMIT] == (cur_o > $past(limit_i)))
		else $error("limit flag wrong");
	c_interval_done: cover property (@(posedge clk_i) disable iff (rst_i) done_o && cur_o != 8'h00);
endmodule
`default_nettype wire

// File: rtl/processor_hot_duty_monitor.sv
//Contract
// - Measure asserted time per line, 1/256 steps
// - Interval end loads current reading register
// - Average becomes (old average + old current)/2
// - Writing either current register restarts both
// - Half-count bias; any assertion reads at least 01h
// - Seven band status bits from the reading
// - Status bit when reading exceeds user limit
// - Two lines measured on separate counters; restart, interval and sleep shared
// - Sleep halts monitor, clears current, keeps average
// - First reading after wake loads current and average
// - Short option mirrors external assertion onto other line
// - Regulator hot pulls matching line low quickly
// - Short option: regulator hot pulls both lines
// - Software PWM override on lines, shorted together only with the short option
`timescale 1ns/1ps
`default_nettype none
module processor_hot_duty_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Open-drain throttle lines, active low
	input wire logic cpu1_throttle_line_i,
	output logic cpu1_throttle_line_o,
	output logic cpu1_throttle_line_oe_o,
	input wire logic cpu2_throttle_line_i,
	output logic cpu2_throttle_line_o,
	output logic cpu2_throttle_line_oe_o,
	// Regulator hot inputs, active low
	input wire logic [1:0] regulator_overtemp_in_n_i,
	// Interrupt
	output logic irq_o
);
	import hot_duty_pkg::*;

	typedef struct packed {
		logic [1:0] drive;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic short_en;
		sleep_e sleep;
		logic [15:0] slot_len;
		logic [7:0] limit1;
		logic [7:0] limit2;
		logic [1:0] ovr_en;
		logic [7:0] ovr_duty;
		logic [3:0] int_stat;
		logic [3:0] int_en;
		logic restart;
	} top_s;
	top_s s, next_s;

	logic [1:0] line_in;
	logic [1:0] asserted;
	logic [1:0] ext;
	logic [1:0] vr_hot;
	logic [1:0] ovr_on;
	logic pwm;
	logic run;
	logic wr_go;
	logic rd_go;
	logic [31:0] wmerge;
	logic [31:0] rword;
	logic rd_hit;
	logic [7:0] cur1, cur2, avg1, avg2, stat1, stat2;
	logic done1, done2, over1, over2;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? d[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin side
	assign line_in = {cpu2_throttle_line_i, cpu1_throttle_line_i};
	assign asserted = ~line_in;
	// An external agent is holding the line when it is low and we are not
	assign ext = asserted & ~s.drive;
	assign vr_hot = ~regulator_overtemp_in_n_i;
	assign ovr_on = s.ovr_en & {2{pwm}};
	assign run = (s.sleep == SLEEP_S0);

	pwm_override u_pwm (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.duty_i(s.ovr_duty),
		.pwm_o(pwm)
	);

	throttle_channel u_ch1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.asserted_i(asserted[0]),
		.run_i(run),
		.restart_i(s.restart),
		.slot_len_i(s.slot_len),
		.limit_i(s.limit1),
		.cur_o(cur1),
		.avg_o(avg1),
		.status_o(stat1),
		.done_o(done1),
		.over_o(over1)
	);

	throttle_channel u_ch2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.asserted_i(asserted[1]),
		.run_i(run),
		.restart_i(s.restart),
		.slot_len_i(s.slot_len),
		.limit_i(s.limit2),
		.cur_o(cur2),
		.avg_o(avg2),
		.status_o(stat2),
		.done_o(done2),
		.over_o(over2)
	);

	////////////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb begin
		rword = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr_i)
			OFS_CTRL: rword = {29'h0, s.sleep, s.short_en};
			OFS_INTERVAL: rword = {16'h0, s.slot_len};
			OFS_CUR1: rword = {24'h0, cur1};
			OFS_CUR2: rword = {24'h0, cur2};
			OFS_AVG1: rword = {24'h0, avg1};
			OFS_AVG2: rword = {24'h0, avg2};
			OFS_LIMIT1: rword = {24'h0, s.limit1};
			OFS_LIMIT2: rword = {24'h0, s.limit2};
			OFS_STAT1: rword = {24'h0, stat1};
			OFS_STAT2: rword = {24'h0, stat2};
			OFS_INT_STAT: rword = {28'h0, s.int_stat};
			OFS_INT_CLR: rword = 32'h0000_0000;
			OFS_INT_EN: rword = {28'h0, s.int_en};
			OFS_OVR: rword = {16'h0, s.ovr_duty, 6'h0, s.ovr_en};
			default: rd_hit = 1'b0;
		endcase
	end

	// Both write channels are taken together; one transfer in flight at a time
	assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s.bvalid;
	assign rd_go = s_axi_arvalid_i && !s.rvalid;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.restart = 1'b0;
		wmerge = 32'h0000_0000;
		// Pin drive: registered, so a regulator hot answers in one cycle
		for (int k = 0; k < 2; k++) begin
			next_s.drive[k] = vr_hot[k]
				| ovr_on[k]
				| (s.short_en & (ext[1-k] | vr_hot[1-k] | ovr_on[1-k]));
		end
		// Sticky interrupts: set wins over a clear in the same cycle
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rword;
			next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (wr_go) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			unique case (s_axi_awaddr_i)
				OFS_CTRL: begin
					wmerge = merge({29'h0, s.sleep, s.short_en}, s_axi_wdata_i, s_axi_wstrb_i);
					next_s.short_en = wmerge[CTRL_SHORT_BIT];
					if (wmerge[CTRL_SLEEP_LSB +: 2] != 2'b11) begin
						next_s.sleep = sleep_e'(wmerge[CTRL_SLEEP_LSB +: 2]);
					end
				end
				OFS_INTERVAL: begin
					wmerge = merge({16'h0, s.slot_len}, s_axi_wdata_i, s_axi_wstrb_i);
					next_s.slot_len = wmerge[15:0];
				end
				OFS_CUR1, OFS_CUR2: next_s.restart = 1'b1;
				OFS_LIMIT1: begin
					wmerge = merge({24'h0, s.limit1}, s_axi_wdata_i, s_axi_wstrb_i);
					next_s.limit1 = wmerge[7:0];
				end
				OFS_LIMIT2: begin
					wmerge = merge({24'h0, s.limit2}, s_axi_wdata_i, s_axi_wstrb_i);
					next_s.limit2 = wmerge[7:0];
				end
				OFS_INT_CLR: begin
					wmerge = merge(32'h0, s_axi_wdata_i, s_axi_wstrb_i);
					next_s.int_stat = s.int_stat & ~wmerge[3:0];
				end
				OFS_INT_EN: begin
					wmerge = merge({28'h0, s.int_en}, s_axi_wdata_i, s_axi_wstrb_i);
					next_s.int_en = wmerge[3:0];
				end
				OFS_OVR: begin
					wmerge = merge({16'h0, s.ovr_duty, 6'h0, s.ovr_en}, s_axi_wdata_i,
						s_axi_wstrb_i);
					next_s.ovr_en = wmerge[1:0];
					next_s.ovr_duty = wmerge[OVR_DUTY_LSB +: 8];
				end
				OFS_AVG1, OFS_AVG2, OFS_STAT1, OFS_STAT2, OFS_INT_STAT: begin
					next_s.bresp = RESP_OKAY;
				end
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		next_s.int_stat = next_s.int_stat | {over2, over1, done2, done1};
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '{slot_len: INTERVAL_RST, limit1: LIMIT_RST, limit2: LIMIT_RST,
				sleep: SLEEP_S0, default: '0};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_awready_o = wr_go;
	assign s_axi_wready_o = wr_go;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_arready_o = rd_go;
	assign s_axi_rvalid_o = s.rvalid;
	assign s_axi_rdata_o = s.rdata;
	assign s_axi_rresp_o = s.rresp;
	// Open drain: only ever pull low
	assign cpu1_throttle_line_o = 1'b0;
	assign cpu2_throttle_line_o = 1'b0;
	assign cpu1_throttle_line_oe_o = s.drive[0];
	assign cpu2_throttle_line_oe_o = s.drive[1];
	assign irq_o = |(s.int_stat & s.int_en);

	////////////////////////////////////////////////////////////////////////
	a_vr_hot_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		vr_hot[0] |-> ##[1:2] cpu1_throttle_line_oe_o)
		else $error("regulator hot did not pull line 1");
	a_vr_hot_release: assert property (@(posedge clk_i) disable iff (rst_i)
		(!vr_hot[1] && !s.short_en && !s.ovr_en[1]) |=> !cpu2_throttle_line_oe_o)
		else $error("line 2 held after regulator hot released");
	a_short_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
		(s.short_en && ext[0]) |=> cpu2_throttle_line_oe_o)
		else $error("short option did not mirror line 1");
	a_short_vr_both: assert property (@(posedge clk_i) disable iff (rst_i)
		(s.short_en && vr_hot[1]) |=> (cpu1_throttle_line_oe_o && cpu2_throttle_line_oe_o))
		else $error("short option did not drive both lines");
	a_ovr_follows_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
		(s.ovr_en[0] && pwm) |=> cpu1_throttle_line_oe_o)
		else $error("override pattern not driven");
	a_restart_on_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && s_axi_awaddr_i == OFS_CUR2) |=> s.restart ##1 !s.restart)
		else $error("current write did not restart");
	a_bvalid_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		done1 && s.int_en[IRQ_DONE1] |=> irq_o)
		else $error("interrupt not raised on interval end");
	c_vr_hot: cover property (@(posedge clk_i) disable iff (rst_i) vr_hot[0] ##1 !vr_hot[0]);
	c_short: cover property (@(posedge clk_i) disable iff (rst_i) s.short_en && ext[1]);
	c_wake: cover property (@(posedge clk_i) disable iff (rst_i) !run ##1 run);
endmodule
`default_nettype wire

// File: tb/cpu_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
	// Clock
	input wire logic clk_i,
	// Processor pattern: 0 idle, 1 always, 2 two of four, 3 one of four
	input wire logic [1:0] mode1_i,
	input wire logic [1:0] mode2_i,
	input wire logic [1:0] vr_hot_i,
	// Device pull-down enables
	input wire logic oe1_i,
	input wire logic oe2_i,
	// Resolved pins
	output logic line1_o,
	output logic line2_o,
	output logic [1:0] vr_n_o
);
	logic [1:0] ph = 2'h0;
	function automatic logic pat(input logic [1:0] m, input logic [1:0] p);
		return (m == 2'h1) || (m == 2'h2 && p[1]) || (m == 2'h3 && p == 2'h0);
	endfunction
	// Patterns repeat every slot so the reading does not depend on phase
	always @(posedge clk_i) begin
		ph <= ph + 2'h1;
	end
	// Pulled up, low while either party sinks it; lines kept apart
	assign line1_o = !(pat(mode1_i, ph) || oe1_i);
	assign line2_o = !(pat(mode2_i, ph) || oe2_i);
	assign vr_n_o = ~vr_hot_i;
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import hot_duty_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] seed = 32'h25FC63EC;
	logic [1:0] m1 = 2'h0, m2 = 2'h0, vrh = 2'h0;
	wire logic awready, wready, bvalid, arready, rvalid, l1, l2, oe1, oe2, irq;
	wire logic [1:0] bresp, rresp, vr_n;
	wire logic [31:0] rdata;
	int error_cnt = 0;
	int total_checks = 0;
	int cur[2] = '{0, 0};
	int avg[2] = '{0, 0};
	int lim[2] = '{255, 255};
	bit first = 1'b1;

	processor_hot_duty_monitor uut (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.cpu1_throttle_line_i(l1), .cpu1_throttle_line_o(), .cpu1_throttle_line_oe_o(oe1),
		.cpu2_throttle_line_i(l2), .cpu2_throttle_line_o(), .cpu2_throttle_line_oe_o(oe2),
		.regulator_overtemp_in_n_i(vr_n), .irq_o(irq));

	cpu_side_model far (.clk_i(clk_i), .mode1_i(m1), .mode2_i(m2), .vr_hot_i(vrh),
		.oe1_i(oe1), .oe2_i(oe2), .line1_o(l1), .line2_o(l2), .vr_n_o(vr_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Asserted quarters of the model's four-clock pattern in 1/256 steps, capped at 255
	function automatic int meas(input logic [1:0] m);
		int q;
		q = (m == 2'h1) ? 4 : ((m == 2'h2) ? 2 : ((m == 2'h3) ? 1 : 0));
		return (q * 64 > 255) ? 255 : q * 64;
	endfunction

	function automatic logic [31:0] stat(input int v, input bit full, input int l);
		logic [31:0] s;
		s = 32'h0;
		s[ST_FULL] = full;
		s[ST_B193] = v >= 193 && !full;
		s[ST_B129] = v >= 129 && v < 193;
		s[ST_B65] = v >= 65 && v < 129;
		s[ST_B33] = v >= 33 && v < 65;
		s[ST_B1] = v > 0 && v < 33;
		s[ST_NZ] = v > 0;
		s[ST_LIMIT] = v > l;
		return s;
	endfunction

	// Master changes signals only right after an edge and holds them until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge clk_i); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge clk_i); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY,
			input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata & m, e);
		chk(rresp, er);
	endtask

	// One completed interval, then the model advances and every result is compared
	task automatic step(input bit rs);
		int n;
		n = 0;
		if (rs)
			wr(OFS_CUR2, 32'h0);
		wr(OFS_INT_CLR, 32'hF);
		while (irq !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		// An interval is 256 slots of four clocks; the result must follow within 1100 clocks
		chk(32'(n < 1100), 32'h1);
		for (int c = 0; c < 2; c++) begin
			avg[c] = first ? meas(c ? m2 : m1) : (avg[c] + cur[c]) / 2;
			cur[c] = meas(c ? m2 : m1);
		end
		first = 1'b0;
		rd(OFS_CUR1, 32'(cur[0]));
		rd(OFS_AVG1, 32'(avg[0]));
		rd(OFS_STAT1, stat(cur[0], m1 == 2'h1, lim[0]));
		rd(OFS_CUR2, 32'(cur[1]));
		rd(OFS_AVG2, 32'(avg[1]));
		rd(OFS_STAT2, stat(cur[1], m2 == 2'h1, lim[1]));
	endtask

	task automatic pins(input logic [1:0] e);
		repeat (3) @(posedge clk_i);
		chk({oe2, oe1}, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #4 clk_i = ~clk_i;
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		$display("FAIL %0t watchdog expired", $time);
		stop_test();
	end

	initial begin
		logic [1:0] t1[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
		logic [1:0] t2[6] = '{2'h0, 2'h0, 2'h3, 2'h2, 2'h1, 2'h1};
		bit low;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(OFS_INTERVAL, 32'(INTERVAL_RST));
		rd(OFS_LIMIT1, 32'(LIMIT_RST));
		rd(OFS_CTRL, 32'h0);
		rd(8'h3C, 32'h0, RESP_SLVERR);
		wr(8'h3C, 32'h1, RESP_SLVERR);
		wr(OFS_AVG1, 32'h55);
		rd(OFS_AVG1, 32'h0);
		// Short slots keep each interval near a thousand clocks
		wr(OFS_INTERVAL, 32'h4);
		wr(OFS_INT_EN, 32'h1 << IRQ_DONE1);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			m1 <= t1[i];
			m2 <= t2[i];
			seed = lfsr(seed);
			lim[0] = int'(seed[7:0]);
			lim[1] = meas(t2[i]);
			wr(OFS_LIMIT1, 32'(lim[0]));
			wr(OFS_LIMIT2, 32'(lim[1]));
			step(i < 5);
		end
		wr(OFS_CTRL, 32'h1 << CTRL_SLEEP_LSB);
		wr(OFS_INT_CLR, 32'hF);
		cur = '{0, 0};
		rd(OFS_CUR1, 32'h0);
		rd(OFS_AVG1, 32'(avg[0]));
		wr(OFS_CTRL, 32'h2 << CTRL_SLEEP_LSB);
		repeat (1100) @(posedge clk_i);
		chk(irq, 1'b0);
		rd(OFS_CUR2, 32'h0);
		rd(OFS_AVG2, 32'(avg[1]));
		@(posedge clk_i);
		m1 <= 2'h2;
		m2 <= 2'h3;
		wr(OFS_CTRL, 32'h0);
		first = 1'b1;
		step(1'b0);
		step(1'b0);
		// Masked event stays out of the interrupt line but is still recorded
		wr(OFS_INT_EN, 32'h0);
		wr(OFS_INT_CLR, 32'hF);
		low = 1'b1;
		repeat (1100) begin
			@(posedge clk_i);
			low &= (irq === 1'b0);
		end
		chk(low, 1'b1);
		rd(OFS_INT_STAT, 32'h3, RESP_OKAY, 32'h3);
		@(posedge clk_i);
		m1 <= 2'h0;
		m2 <= 2'h0;
		vrh <= 2'b01;
		pins(2'b01);
		vrh <= 2'b00;
		pins(2'b00);
		wr(OFS_CTRL, 32'h1 << CTRL_SHORT_BIT);
		vrh <= 2'b10;
		pins(2'b11);
		vrh <= 2'b00;
		m1 <= 2'h1;
		pins(2'b10);
		m1 <= 2'h0;
		pins(2'b00);
		wr(OFS_OVR, 32'h0000FF01);
		pins(2'b11);
		wr(OFS_CTRL, 32'h0);
		pins(2'b01);
		wr(OFS_OVR, 32'h0);
		pins(2'b00);
		stop_test();
	end
endmodule
`default_nettype wire
